// file: rtl/fdd_diag_block.sv
/*
 Standard six-byte diagnostics block of a fieldbus follower plus the header
 of its device-specific diagnostics, all read over a plain register port.
 Assumes one core clock, synchronous reset, and that the bus stack feeds
 the parameterizing controller address and events from the same clock.
*/
`timescale 1ns/1ns
module fdd_diag_block
  import fdd_pkg::*;
#(
  parameter logic [15:0] IDENT_VALUE = IDENT_DEFAULT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Parameterization from the bus stack
  input wire logic param_done,
  input wire logic [7:0] param_ctrl_addr,
  // Parallel diagnostics image
  output logic [7:0] diag_ss1,
  output logic [7:0] diag_ss2,
  output logic [7:0] diag_ss3,
  output logic [7:0] diag_ctrl_addr,
  output logic [7:0] diag_ident_lo,
  output logic [7:0] diag_ident_hi,
  output logic [7:0] dev_hdr,
  // Delivery style: 1 = acknowledged interrupt
  output logic report_needs_ack
);
  logic [7:0] ctrl;
  logic [5:0] dev_len;
  logic param_bad;
  logic cfg_reject;
  logic reparam;
  logic [7:0] ctrl_addr;
  logic [7:0] next_ss1;
  logic [7:0] next_ss2;
  logic [7:0] next_ss3;
  logic [7:0] hdr_w;

  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] idx, input logic w);
    wr_hit = w && (a == idx);
  endfunction : wr_hit

  // Control register steers the status bits
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl <= 8'h00;
    end else if (wr_hit(reg_addr, REG_CTRL, reg_wr)) begin
      ctrl <= reg_wdata;
    end
  end

  // Length of the device-specific field
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dev_len <= DEVLEN_DEFAULT;
    end else if (wr_hit(reg_addr, REG_DEVLEN, reg_wr)) begin
      dev_len <= reg_wdata[5:0];
    end
  end

  // Sticky bad-frame flag; new event beats clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      param_bad <= 1'b0;
    end else if (wr_hit(reg_addr, REG_EVENT, reg_wr) && reg_wdata[EVT_PARAM_BAD]) begin
      param_bad <= 1'b1;
    end else if (param_done || (wr_hit(reg_addr, REG_EVENT, reg_wr) && reg_wdata[EVT_CLEAR_ALL])) begin
      param_bad <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_reject <= 1'b0;
    end else if (wr_hit(reg_addr, REG_EVENT, reg_wr) && reg_wdata[EVT_CFG_REJECT]) begin
      cfg_reject <= 1'b1;
    end else if (param_done || (wr_hit(reg_addr, REG_EVENT, reg_wr) && reg_wdata[EVT_CLEAR_ALL])) begin
      cfg_reject <= 1'b0;
    end
  end

  // Reparameterization request, set from reset until served
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reparam <= 1'b1;
    end else if (wr_hit(reg_addr, REG_EVENT, reg_wr) && reg_wdata[EVT_REPARAM]) begin
      reparam <= 1'b1;
    end else if (param_done) begin
      reparam <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_addr <= CTRL_ADDR_NONE;
    end else if (param_done) begin
      ctrl_addr <= param_ctrl_addr;
    end else if (wr_hit(reg_addr, REG_EVENT, reg_wr) && reg_wdata[EVT_REPARAM]) begin
      ctrl_addr <= CTRL_ADDR_NONE;
    end
  end

  always_comb begin
    next_ss1 = 8'h00;
    next_ss1[SS1_PARAM_BAD] = param_bad;
    next_ss1[SS1_EXT_DIAG] = ctrl[CTL_EXT_DIAG];
    next_ss1[SS1_CFG_REJECT] = cfg_reject;
    next_ss1[SS1_NOT_READY] = ctrl[CTL_NOT_READY];
    next_ss2 = 8'h00;
    next_ss2[SS2_WATCHDOG] = ctrl[CTL_WATCHDOG];
    next_ss2[SS2_FROM_FOLLOWER] = 1'b1;
    // Static hold, masked by reparam priority
    next_ss2[SS2_HOLD] = ctrl[CTL_HOLD] && !reparam;
    next_ss2[SS2_REPARAM] = reparam;
    next_ss3 = 8'h00;
    next_ss3[SS3_OVERFLOW] = ctrl[CTL_OVERFLOW];
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      diag_ss1 <= 8'h00;
      diag_ss2 <= 8'h00;
      diag_ss3 <= 8'h00;
      diag_ctrl_addr <= CTRL_ADDR_NONE;
      diag_ident_lo <= 8'h00;
      diag_ident_hi <= 8'h00;
    end else begin
      diag_ss1 <= next_ss1;
      diag_ss2 <= next_ss2;
      diag_ss3 <= next_ss3;
      diag_ctrl_addr <= ctrl_addr;
      diag_ident_lo <= IDENT_VALUE[7:0];
      diag_ident_hi <= IDENT_VALUE[15:8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      report_needs_ack <= 1'b0;
    end else begin
      report_needs_ack <= ctrl[CTL_DPV1];
    end
  end

  fdd_hdr_byte #(
    .LW(LEN_BITS)
  ) u_hdr (
    .core_clk(core_clk),
    .srst(srst),
    .field_len(dev_len),
    .hdr_byte(hdr_w)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dev_hdr <= {HDR_TAG, DEVLEN_DEFAULT};
    end else begin
      dev_hdr <= hdr_w;
    end
  end

  // Read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_DIAG0: reg_rdata <= diag_ss1;
        REG_DIAG1: reg_rdata <= diag_ss2;
        REG_DIAG2: reg_rdata <= diag_ss3;
        REG_DIAG3: reg_rdata <= diag_ctrl_addr;
        REG_DIAG4: reg_rdata <= diag_ident_lo;
        REG_DIAG5: reg_rdata <= diag_ident_hi;
        REG_CTRL: reg_rdata <= ctrl;
        REG_HDR: reg_rdata <= dev_hdr;
        REG_DEVLEN: reg_rdata <= {2'b00, dev_len};
        REG_IDENT: reg_rdata <= {1'b0, ctrl[CTL_STATUS_VARIANT], 6'h00};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  property p_absent_zero;
    @(posedge core_clk) disable iff (srst)
    1'b1 |=> !diag_ss1[SS1_NODE_ABSENT] && !diag_ss1[SS1_FOREIGN_LOCK]
      && !diag_ss1[SS1_IMPLAUSIBLE] && !diag_ss1[SS1_UNSUPPORTED];
  endproperty
  a_absent_zero: assert property (p_absent_zero) else $error("controller bits driven");

  property p_origin_one;
    @(posedge core_clk) disable iff (srst)
    !$past(srst) |-> diag_ss2[SS2_FROM_FOLLOWER] && !diag_ss2[SS2_SYNC] && !diag_ss2[SS2_FREEZE];
  endproperty
  a_origin_one: assert property (p_origin_one) else $error("status 2 fixed bits wrong");

  property p_reparam_prio;
    @(posedge core_clk) disable iff (srst)
    diag_ss2[SS2_REPARAM] |-> !diag_ss2[SS2_HOLD];
  endproperty
  a_reparam_prio: assert property (p_reparam_prio) else $error("hold beside reparam");

  property p_reserved;
    @(posedge core_clk) disable iff (srst)
    (diag_ss3[6:0] == 7'h00) && !diag_ss2[6] && !diag_ss2[7];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_bad_frame;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == REG_EVENT && reg_wdata[EVT_PARAM_BAD]) |=> ##1 diag_ss1[SS1_PARAM_BAD];
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("bad frame not flagged");

  property p_cfg_rej;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == REG_EVENT && reg_wdata[EVT_CFG_REJECT]) |=> ##1 diag_ss1[SS1_CFG_REJECT];
  endproperty
  a_cfg_rej: assert property (p_cfg_rej) else $error("config reject lost");

  property p_addr;
    @(posedge core_clk) disable iff (srst)
    param_done |=> ##1 (diag_ctrl_addr == $past(param_ctrl_addr, 2));
  endproperty
  a_addr: assert property (p_addr) else $error("controller address wrong");

  property p_ident;
    @(posedge core_clk) disable iff (srst)
    !$past(srst) |-> diag_ident_hi == IDENT_VALUE[15:8] && diag_ident_lo == IDENT_VALUE[7:0];
  endproperty
  a_ident: assert property (p_ident) else $error("identifier order wrong");

  property p_watchdog;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == REG_CTRL) |=> ##1 (diag_ss2[SS2_WATCHDOG] == $past(reg_wdata[CTL_WATCHDOG], 2));
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog bit wrong");

  property p_ext_diag;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == REG_CTRL) |=> ##1 (diag_ss1[SS1_EXT_DIAG] == $past(reg_wdata[CTL_EXT_DIAG], 2));
  endproperty
  a_ext_diag: assert property (p_ext_diag) else $error("extended diagnostics bit wrong");

  property p_not_ready;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == REG_CTRL) |=> ##1 (diag_ss1[SS1_NOT_READY] == $past(reg_wdata[CTL_NOT_READY], 2));
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("not ready bit wrong");

  property p_overflow;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == REG_CTRL) |=> ##1 (diag_ss3[SS3_OVERFLOW] == $past(reg_wdata[CTL_OVERFLOW], 2));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow bit wrong");

  property p_ack_style;
    @(posedge core_clk) disable iff (srst)
    (reg_wr && reg_addr == REG_CTRL) |=> ##1 (report_needs_ack == $past(reg_wdata[CTL_DPV1], 2));
  endproperty
  a_ack_style: assert property (p_ack_style) else $error("delivery style wrong");
endmodule : fdd_diag_block

// file: pkg/fdd_pkg.sv
/*
 Constants for the standard diagnostics block builder: byte indices,
 status bit positions, reset values and sizes.
 Assumes a single core clock domain and a plain register port.
*/
package fdd_pkg;
  // Register indices on the plain port (byte address = index)
  localparam logic [3:0] REG_DIAG0 = 4'h0;
  localparam logic [3:0] REG_DIAG1 = 4'h1;
  localparam logic [3:0] REG_DIAG2 = 4'h2;
  localparam logic [3:0] REG_DIAG3 = 4'h3;
  localparam logic [3:0] REG_DIAG4 = 4'h4;
  localparam logic [3:0] REG_DIAG5 = 4'h5;
  localparam logic [3:0] REG_CTRL = 4'h6;
  localparam logic [3:0] REG_EVENT = 4'h7;
  localparam logic [3:0] REG_HDR = 4'h8;
  localparam logic [3:0] REG_DEVLEN = 4'h9;
  localparam logic [3:0] REG_IDENT = 4'hA;
  // Station status 1 bit positions
  localparam int SS1_FOREIGN_LOCK = 7;
  localparam int SS1_PARAM_BAD = 6;
  localparam int SS1_IMPLAUSIBLE = 5;
  localparam int SS1_UNSUPPORTED = 4;
  localparam int SS1_EXT_DIAG = 3;
  localparam int SS1_CFG_REJECT = 2;
  localparam int SS1_NOT_READY = 1;
  localparam int SS1_NODE_ABSENT = 0;
  // Station status 2 bit positions
  localparam int SS2_SYNC = 5;
  localparam int SS2_FREEZE = 4;
  localparam int SS2_WATCHDOG = 3;
  localparam int SS2_FROM_FOLLOWER = 2;
  localparam int SS2_HOLD = 1;
  localparam int SS2_REPARAM = 0;
  // Station status 3 bit position
  localparam int SS3_OVERFLOW = 7;
  // Control register bit positions
  localparam int CTL_EXT_DIAG = 0;
  localparam int CTL_NOT_READY = 1;
  localparam int CTL_WATCHDOG = 2;
  localparam int CTL_HOLD = 3;
  localparam int CTL_OVERFLOW = 4;
  localparam int CTL_DPV1 = 5;
  localparam int CTL_STATUS_VARIANT = 6;
  // Event register bit positions (write 1 to set, sticky; EVT_CLEAR_ALL clears EVT_PARAM_BAD and EVT_CFG_REJECT, not EVT_REPARAM, EVT_PARAM_OK unused)
  localparam int EVT_PARAM_BAD = 0;
  localparam int EVT_CFG_REJECT = 1;
  localparam int EVT_REPARAM = 2;
  localparam int EVT_PARAM_OK = 3;
  localparam int EVT_CLEAR_ALL = 4;
  // Reset values and sizes
  localparam logic [7:0] CTRL_ADDR_NONE = 8'h00_FF;
  localparam logic [15:0] IDENT_DEFAULT = 16'h0000_1234; // Arbitrary value
  localparam logic [5:0] DEVLEN_DEFAULT = 6'h00_06;
  localparam logic [1:0] HDR_TAG = 2'h0_0;
  localparam int LEN_BITS = 6;
  localparam int DIAG_BYTES = 6;
endpackage : fdd_pkg

// file: rtl/fdd_hdr_byte.sv
/*
 Builds the header byte of the device-specific diagnostics field.
 Assumes the length is already clamped by the caller.
*/
`timescale 1ns/1ns
module fdd_hdr_byte
  import fdd_pkg::*;
#(
  parameter int LW = LEN_BITS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Field length including header
  input wire logic [LW-1:0] field_len,
  // Header byte
  output logic [7:0] hdr_byte
);
  // Two tag bits leave exactly six for the length
  if (LW != LEN_BITS) begin : g_bad_lw
    $error("fdd_hdr_byte: length field must be 6 bits");
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hdr_byte <= {HDR_TAG, DEVLEN_DEFAULT};
    end else begin
      hdr_byte <= {HDR_TAG, field_len};
    end
  end

  property p_hdr_tag;
    @(posedge core_clk) disable iff (srst)
    !$past(srst) |-> (hdr_byte[7:6] == 2'b00) && (hdr_byte[5:0] == $past(field_len));
  endproperty
  a_hdr_tag: assert property (p_hdr_tag) else $error("header byte wrong");
endmodule : fdd_hdr_byte

// file: testbench/fdd_master_model.sv
/*
 Controller-side model: hands a parameter assignment to the follower and
 evaluates station status 1 as the polling controller would see it.
 Assumes the diagnostics image is read in the core clock domain.
*/
`timescale 1ns/1ns
module fdd_master_model
  import fdd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Bench control
  input wire logic assign_req,
  input wire logic [7:0] assign_addr,
  input wire logic [7:0] own_addr,
  // Follower image
  input wire logic [7:0] diag_ss1,
  input wire logic [7:0] diag_ctrl_addr,
  // Toward the follower
  output logic param_done,
  output logic [7:0] param_ctrl_addr,
  // Evaluated status 1
  output logic [7:0] seen_ss1
);
  logic [7:0] last_addr;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      param_done <= 1'b0;
      last_addr <= 8'h00;
    end else begin
      param_done <= assign_req;
      if (assign_req) begin
        last_addr <= assign_addr;
      end
    end
  end

  // Address is only valid with the pulse, so it must not linger
  assign param_ctrl_addr = param_done ? last_addr : ~last_addr;

  always_comb begin
    seen_ss1 = diag_ss1;
    seen_ss1[SS1_FOREIGN_LOCK] = (diag_ctrl_addr != 8'h00_FF) && (diag_ctrl_addr != own_addr);
  end
endmodule : fdd_master_model

// file: testbench/fdd_diag_block_bench.sv
/*
 Self-checking bench for the diagnostics block: register port tasks and
 a controller model on the parameterization side.
 Assumes the block answers reads one cycle after the strobe.
*/
`timescale 1ns/1ns
module fdd_diag_block_bench
  import fdd_pkg::*;
;
  // Arbitrary identifier value
  localparam logic [15:0] IDV = 16'hA5C3;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic assign_req = 1'b0;
  logic [7:0] assign_addr = 8'h00;
  logic [7:0] own_addr = 8'h2A;
  logic [7:0] reg_rdata, diag_ss1, diag_ss2, diag_ss3, diag_ctrl_addr;
  logic [7:0] diag_ident_lo, diag_ident_hi, dev_hdr, seen_ss1, param_ctrl_addr;
  logic param_done, report_needs_ack;
  logic [7:0] e1 [5] = '{8'h08, 8'h02, 8'h00, 8'h00, 8'h00};
  logic [7:0] e2 [5] = '{8'h04, 8'h04, 8'h0C, 8'h06, 8'h04};
  logic [7:0] e3 [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
  int num_errors = 0;
  int num_checks = 0;

  always #4 core_clk = ~core_clk;

  fdd_diag_block #(.IDENT_VALUE(IDV)) dut_u (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .param_done(param_done), .param_ctrl_addr(param_ctrl_addr), .diag_ss1(diag_ss1),
    .diag_ss2(diag_ss2), .diag_ss3(diag_ss3), .diag_ctrl_addr(diag_ctrl_addr),
    .diag_ident_lo(diag_ident_lo), .diag_ident_hi(diag_ident_hi), .dev_hdr(dev_hdr),
    .report_needs_ack(report_needs_ack));

  fdd_master_model ctl_u (.core_clk(core_clk), .srst(srst), .assign_req(assign_req),
    .assign_addr(assign_addr), .own_addr(own_addr), .diag_ss1(diag_ss1),
    .diag_ctrl_addr(diag_ctrl_addr), .param_done(param_done),
    .param_ctrl_addr(param_ctrl_addr), .seen_ss1(seen_ss1));

  task automatic summarize();
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rdc

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic assign_params(input logic [7:0] a);
    @(posedge core_clk);
    assign_req <= 1'b1;
    assign_addr <= a;
    @(posedge core_clk);
    assign_req <= 1'b0;
    settle(3);
  endtask : assign_params

  task automatic reset_image();
    chk(diag_ss1, 8'h00);
    chk(diag_ss2, 8'h05);
    chk(diag_ss3, 8'h00);
    chk(diag_ctrl_addr, 8'hFF);
  endtask : reset_image

  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    settle(2);
    reset_image();
    chk(diag_ident_lo, IDV[7:0]);
    chk(diag_ident_hi, IDV[15:8]);
    chk(dev_hdr, 8'h06);
    // Read-only bytes ignore writes
    wr(REG_DIAG0, 8'hFF);
    rdc(REG_DIAG0, 8'h00);
    rdc(REG_DIAG5, IDV[15:8]);
    rdc(REG_DIAG4, IDV[7:0]);
    rdc(REG_DIAG3, 8'hFF);
    rdc(4'hF, 8'h00);
    assign_params(8'h31);
    chk(diag_ctrl_addr, 8'h31);
    chk(diag_ss2, 8'h04);
    chk(seen_ss1, 8'h80);
    assign_params(8'h2A);
    chk(seen_ss1, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(REG_CTRL, 8'h01 << i);
      settle(2);
      chk(diag_ss1, e1[i]);
      chk(diag_ss2, e2[i]);
      chk(diag_ss3, e3[i]);
      rdc(REG_CTRL, 8'h01 << i);
    end
    // Back-to-back events, then clear
    wr(REG_EVENT, 8'h01);
    wr(REG_EVENT, 8'h02);
    settle(2);
    chk(diag_ss1, 8'h44);
    wr(REG_EVENT, 8'h10);
    settle(2);
    chk(diag_ss1, 8'h00);
    // Reparam over hold: bit 0 wins
    wr(REG_CTRL, 8'h08);
    wr(REG_EVENT, 8'h05);
    settle(2);
    chk(diag_ss1, 8'h40);
    chk(diag_ss2, 8'h05);
    chk(diag_ctrl_addr, 8'hFF);
    assign_params(8'h2A);
    chk(diag_ss1, 8'h00);
    chk(diag_ss2, 8'h06);
    wr(REG_CTRL, 8'h00);
    settle(2);
    chk(diag_ss2, 8'h04);
    wr(REG_DEVLEN, 8'hFF);
    settle(3);
    chk(dev_hdr, 8'h3F);
    wr(REG_DEVLEN, 8'h0D);
    settle(3);
    rdc(REG_HDR, 8'h0D);
    wr(REG_CTRL, 8'h60);
    settle(2);
    chk({7'h00, report_needs_ack}, 8'h01);
    rdc(REG_IDENT, 8'h40);
    wr(REG_CTRL, 8'h00);
    settle(2);
    chk({7'h00, report_needs_ack}, 8'h00);
    rdc(REG_IDENT, 8'h00);
    // Mid-run reset restores the unassigned image
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    settle(2);
    reset_image();
    chk(dev_hdr, 8'h06);
    summarize();
  end

  // Hang guard
  initial begin
    #400000;
    num_errors++;
    summarize();
  end
endmodule : fdd_diag_block_bench
